// File: core/smbus_index_block_target.sv
// serial target for indexed block write and indexed block read
// assumes open-drain pins resolved outside; host owns the serial clock
`timescale 1ns/100ps
`default_nettype none
module smbus_index_block_target
  import smbus_pkg::*;
#(
  parameter int DEPTH = REG_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_strap_i,
  input wire logic power_good_powerdown_input_i,
  output wr_port_t wr_o,
  input wire logic wr_ready_i
);
  localparam int IW = $clog2(DEPTH);

  // whole state of the block in one record
  typedef struct packed {
    logic scl_m; // first sync stages
    logic scl_q;
    logic scl_p; // previous synced level, for edges
    logic sda_m;
    logic sda_q;
    logic sda_p;
    logic strap_m;
    logic strap_q;
    logic pg_m;
    logic pg_q;
    logic latched; // strap already caught
    logic sel; // caught strap value
    st_t st;
    ph_t ph;
    logic [7:0] sh; // byte shifter
    logic [3:0] bcnt; // bits seen in the byte
    logic [7:0] idx; // index pointer
    logic rw; // last address byte asked to read
    logic ackit; // acknowledge current byte
    logic nack; // host refused the last byte
    logic pushed; // received byte already buffered
    logic drv; // pull data low
    logic hold; // stretch clock low
    logic [DEPTH-1:0][7:0] regs;
    wr_word_t [1:0] ent; // two-entry buffer, ent[0] is head
    logic [1:0] fill;
  } state_t;

  state_t q_ff;
  state_t nxt_q;
  logic rise; // serial clock edges and frame events
  logic fall;
  logic start;
  logic stop;
  logic [6:0] my_addr;
  logic pop;

  // edges seen on the synchronised copies only
  assign rise = q_ff.scl_q & ~q_ff.scl_p;
  assign fall = ~q_ff.scl_q & q_ff.scl_p;
  assign start = q_ff.scl_q & q_ff.scl_p & q_ff.sda_p & ~q_ff.sda_q;
  assign stop = q_ff.scl_q & q_ff.scl_p & ~q_ff.sda_p & q_ff.sda_q;
  // address follows the caught strap
  assign my_addr = q_ff.sel ? ADDR_STRAP1 : ADDR_STRAP0;
  // head leaves the buffer when the user side takes it
  assign pop = (q_ff.fill != 2'h0) && wr_ready_i;

  // next state
  always_comb begin
    nxt_q = q_ff;
    // two flops on every serial, strap and power-good pin before logic sees it
    nxt_q.scl_m = scl_i;
    nxt_q.scl_q = q_ff.scl_m;
    nxt_q.scl_p = q_ff.scl_q;
    nxt_q.sda_m = sda_i;
    nxt_q.sda_q = q_ff.sda_m;
    nxt_q.sda_p = q_ff.sda_q;
    nxt_q.strap_m = address_select_strap_i;
    nxt_q.strap_q = q_ff.strap_m;
    nxt_q.pg_m = power_good_powerdown_input_i;
    nxt_q.pg_q = q_ff.pg_m;
    // drain the head of the buffer
    if (pop) begin
      nxt_q.ent[0] = q_ff.ent[1];
      nxt_q.fill = q_ff.fill - 2'h1;
    end
    // strap caught once, later power cycles keep it
    if (q_ff.pg_q && !q_ff.latched) begin
      nxt_q.latched = 1'b1;
      nxt_q.sel = q_ff.strap_q;
    end
    case (q_ff.st)
      S_RX: begin
        if (rise) begin
          nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_q};
          nxt_q.bcnt = q_ff.bcnt + 4'h1;
        end else if (fall && q_ff.bcnt == BYTE_BITS) begin
          nxt_q.st = S_RXACK;
          nxt_q.ackit = 1'b1;
          nxt_q.pushed = 1'b1;
          case (q_ff.ph)
            P_ADDR: begin
              // answer only our own address, once strap is known
              nxt_q.ackit = q_ff.latched &&
                (q_ff.sh[7:1] == my_addr);
              nxt_q.rw = q_ff.sh[0];
              if (!nxt_q.ackit) begin
                nxt_q.st = S_IDLE;
              end
            end
            P_INDEX: begin
              nxt_q.idx = q_ff.sh;
            end
            P_COUNT: begin
              nxt_q.ackit = 1'b1;
            end
            default: begin
              nxt_q.pushed = 1'b0; // data waits for buffer room
            end
          endcase
        end
      end
      S_RXACK: begin
        if (!q_ff.pushed && nxt_q.fill != BUF_DEPTH) begin
          // store and buffer the byte; clock is held until here
          nxt_q.ent[nxt_q.fill] = '{index: q_ff.idx, data: q_ff.sh};
          nxt_q.fill = nxt_q.fill + 2'h1;
          if (q_ff.idx < 8'(DEPTH)) begin
            nxt_q.regs[q_ff.idx[IW-1:0]] = q_ff.sh;
          end
          nxt_q.idx = q_ff.idx + 8'h01;
          nxt_q.pushed = 1'b1;
          // byte settled; next serial fall ends the acknowledge bit
        end else if (fall && q_ff.pushed) begin
          nxt_q.bcnt = 4'h0;
          if (q_ff.ph == P_ADDR && q_ff.rw) begin
            // count goes out first, before any register
            nxt_q.st = S_TX;
            nxt_q.sh = q_ff.regs[BC_INDEX] & BC_MASK;
          end else begin
            nxt_q.st = S_RX;
            case (q_ff.ph)
              P_ADDR: nxt_q.ph = P_INDEX;
              P_INDEX: nxt_q.ph = P_COUNT;
              default: nxt_q.ph = P_DATA;
            endcase
          end
        end
      end
      S_TX: begin
        // count bits on rise; the host samples while clock is high
        if (rise) begin
          nxt_q.bcnt = q_ff.bcnt + 4'h1;
        end else if (fall) begin
          if (q_ff.bcnt == BYTE_BITS) begin
            nxt_q.st = S_TXACK; // release for host answer
          end else begin
            nxt_q.sh = {q_ff.sh[6:0], 1'b1};
          end
        end
      end
      S_TXACK: begin
        // host answer sampled on the rise of the ninth clock
        if (rise) begin
          nxt_q.nack = q_ff.sda_q;
        end else if (fall) begin
          if (q_ff.nack) begin
            nxt_q.st = S_IDLE;
          end else begin
            // next register, pointer steps after each byte sent
            nxt_q.sh = (q_ff.idx < 8'(DEPTH)) ?
              q_ff.regs[q_ff.idx[IW-1:0]] : EMPTY_BYTE;
            nxt_q.idx = q_ff.idx + 8'h01;
            nxt_q.bcnt = 4'h0;
            nxt_q.st = S_TX;
          end
        end
      end
      default: begin
        nxt_q.st = S_IDLE; // wait for a start
      end
    endcase
    // frame events override the byte engine
    if (start) begin
      nxt_q.st = S_RX;
      nxt_q.ph = P_ADDR;
      nxt_q.bcnt = 4'h0;
      nxt_q.pushed = 1'b1;
    end else if (stop) begin
      nxt_q.st = S_IDLE;
    end
    // pin drives registered so they never glitch
    nxt_q.drv = (nxt_q.st == S_RXACK && nxt_q.ackit && nxt_q.pushed)
      || (nxt_q.st == S_TX && !nxt_q.sh[7]);
    // stretching only while a data byte waits for buffer room
    nxt_q.hold = (nxt_q.st == S_RXACK) && !nxt_q.pushed;
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= '0;
      q_ff.scl_m <= 1'b1; // idle bus reads high, no false edge
      q_ff.scl_q <= 1'b1;
      q_ff.scl_p <= 1'b1;
      q_ff.sda_m <= 1'b1;
      q_ff.sda_q <= 1'b1;
      q_ff.sda_p <= 1'b1;
      q_ff.pushed <= 1'b1;
      q_ff.regs[BC_INDEX] <= BC_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = q_ff.hold;
  assign sda_oe_o = q_ff.drv;
  assign wr_o.valid = q_ff.fill != 2'h0;
  assign wr_o.word = q_ff.ent[0];

  // checks run on the system clock, quiet during reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // helper views for the checks
  sequence s_byte_end;
    fall && q_ff.st == S_RX && q_ff.bcnt == BYTE_BITS;
  endsequence
  sequence s_addr_hit;
    s_byte_end ##0 q_ff.ph == P_ADDR && q_ff.latched
      && q_ff.sh[7:1] == my_addr;
  endsequence

  a_addr_ack: assert property (s_addr_hit |-> ##2 sda_oe_o)
    else $error("own address not acknowledged");
  a_index_load: assert property (
    s_byte_end ##0 q_ff.ph == P_INDEX |=> q_ff.idx == $past(q_ff.sh))
    else $error("index pointer not loaded");
  a_count_ack: assert property (
    s_byte_end ##0 q_ff.ph == P_COUNT |-> ##2 sda_oe_o)
    else $error("count byte not acknowledged");
  a_data_push: assert property (
    s_byte_end ##0 q_ff.ph == P_DATA && q_ff.fill == 2'h0 && !wr_ready_i
    |-> ##2 wr_o.valid && sda_oe_o && wr_o.word.data == $past(q_ff.sh, 2))
    else $error("data byte not stored and acknowledged");
  a_strap_catch: assert property (
    $rose(q_ff.latched) |-> q_ff.sel == $past(q_ff.strap_q))
    else $error("strap not caught at power good");
  a_strap_once: assert property (
    q_ff.latched |=> q_ff.latched && $stable(q_ff.sel))
    else $error("address changed after capture");
  a_read_count: assert property (
    fall && q_ff.st == S_RXACK && q_ff.ph == P_ADDR && q_ff.rw
    && q_ff.pushed |=> q_ff.st == S_TX
    && q_ff.sh == (q_ff.regs[BC_INDEX] & BC_MASK))
    else $error("count not sent first");
  a_idx_step: assert property (
    fall && q_ff.st == S_TXACK && !q_ff.nack
    |=> q_ff.idx == $past(q_ff.idx) + 8'h01)
    else $error("index did not step on read");
  a_nack_release: assert property (
    fall && q_ff.st == S_TXACK && q_ff.nack && !start
    |=> q_ff.st == S_IDLE ##1 !sda_oe_o [*3])
    else $error("data not released after nack");
  a_foreign_ignore: assert property (
    s_byte_end ##0 q_ff.ph == P_ADDR && q_ff.sh[7:1] != my_addr
    |=> q_ff.st == S_IDLE ##1 !sda_oe_o)
    else $error("foreign address answered");
  a_read_ack: assert property (
    s_addr_hit ##0 q_ff.sh[0] |=> q_ff.rw && q_ff.st == S_RXACK)
    else $error("read address not taken");

  // hand-over from address acknowledge to count byte
  sequence s_read_turn;
    fall && q_ff.st == S_RXACK && q_ff.ph == P_ADDR && q_ff.rw
      && q_ff.pushed && !start && !stop;
  endsequence

  // masked count has a low top bit, so the first bit pulls data low
  a_count_first: assert property (s_read_turn |=> sda_oe_o)
    else $error("count byte first bit not driven");
  // a data byte without room must stretch the clock
  a_stretch_full: assert property (
    q_ff.st == S_RXACK && !q_ff.pushed && !start && !stop
    |=> q_ff.pushed || scl_oe_o)
    else $error("data byte neither stored nor stretched");
  // data line is free while the host answers a sent byte
  a_tx_release: assert property (q_ff.st == S_TXACK |-> !sda_oe_o)
    else $error("data line held during host answer");
  // an idle engine touches neither line
  a_idle_quiet: assert property (
    q_ff.st == S_IDLE |-> !sda_oe_o && !scl_oe_o)
    else $error("idle target drives a line");
endmodule // smbus_index_block_target
`default_nettype wire

// File: core/smbus_pkg.sv
// constants and carrier types for the indexed-block serial target
// assumes one 100 MHz clock; serial pins are synchronised inside the target
package smbus_pkg;
  // target addresses for strap low and strap high
  localparam logic [6:0] ADDR_STRAP0 = 7'h68;
  localparam logic [6:0] ADDR_STRAP1 = 7'h6a;
  // register file layout
  localparam int REG_COUNT = 8;
  localparam int BC_INDEX = 7;
  localparam logic [7:0] BC_RESET = 8'h08;
  localparam logic [7:0] BC_MASK = 8'h1f;
  // bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // value shifted out for an index past the register file
  localparam logic [7:0] EMPTY_BYTE = 8'hff;
  // buffer depth
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // bit-level engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_RXACK,
    S_TX,
    S_TXACK
  } st_t;

  // which byte of the frame is being received
  typedef enum logic [1:0] {
    P_ADDR,
    P_INDEX,
    P_COUNT,
    P_DATA
  } ph_t;

  // one written byte and where it went
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } wr_word_t;

  // written-byte stream towards the user side
  typedef struct packed {
    logic valid;
    wr_word_t word;
  } wr_port_t;
endpackage

// File: tb/smbus_host_model.sv
// behavioural serial host: owns the clock line, frames and bytes
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  // half of the 160 ns link period
  localparam int HALF = 80;
  // released lines idle high through the pull-ups
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // release clock and wait out stretching, bounded so a hang cannot stick
  task automatic rise_scl();
    scl_low_o = 1'b0;
    for (int i = 0; i < 3000 && scl_i !== 1'b1; i++) #10;
  endtask
  // start or repeated start; clock stands still between frames
  task automatic start();
    sda_low_o = 1'b0;
    #(HALF/2);
    rise_scl();
    #HALF;
    sda_low_o = 1'b1;
    #HALF;
    scl_low_o = 1'b1;
    #(HALF/2);
  endtask
  // stop leaves both lines released
  task automatic stop();
    sda_low_o = 1'b1;
    #(HALF/2);
    rise_scl();
    #HALF;
    sda_low_o = 1'b0;
    #HALF;
  endtask
  // data changes only while the clock is low
  task automatic put_bit(input logic b);
    sda_low_o = ~b;
    #(HALF/2);
    rise_scl();
    #HALF;
    scl_low_o = 1'b1;
    #(HALF/2);
  endtask
  // sample mid high phase, data line released
  task automatic get_bit(output logic b);
    sda_low_o = 1'b0;
    #(HALF/2);
    rise_scl();
    #(HALF/2);
    b = sda_i;
    #(HALF/2);
    scl_low_o = 1'b1;
    #(HALF/2);
  endtask
  // msb first, then the target's acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  // host acks each byte, nacks the last one
  task automatic get_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(~ack);
  endtask
endmodule // smbus_host_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the indexed-block serial target
// assumes the host model drives the link; written bytes drain at random
`timescale 1ns/100ps
`default_nettype none
module testbench import smbus_pkg::*;;
  logic clk_i, rst_i, strap, pg, wr_ready, scl_oe, sda_oe, scl_o, sda_o;
  logic h_scl, h_sda;
  logic [6:0] addr; // captured target address
  logic [7:0] regs [0:7]; // shadow of the register file
  wire logic scl, sda;
  wr_port_t wr;
  wr_word_t exp_q [$]; // written bytes still to appear
  int num_errors, num_checks;
  // open-drain wires with pull-ups
  assign scl = ~(h_scl | (scl_oe & ~scl_o));
  assign sda = ~(h_sda | (sda_oe & ~sda_o));
  smbus_index_block_target u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .address_select_strap_i(strap),
    .power_good_powerdown_input_i(pg), .wr_o(wr), .wr_ready_i(wr_ready));
  smbus_host_model u_host (.scl_i(scl), .sda_i(sda), .scl_low_o(h_scl),
    .sda_low_o(h_sda));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // watchdog
  initial begin
    #900us;
    num_errors++;
    print_verdict();
  end
  // mostly-low ready, yet each byte drains before the next one lands, so the two-entry buffer never fills
  always @(negedge clk_i) wr_ready <= ($urandom % 4) == 0;
  // each popped head must match the oldest note
  always @(posedge clk_i) begin
    if (!rst_i && wr.valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0, 16'h1);
      else check(wr.word, exp_q.pop_front());
    end
  end
  // address a frame that must be refused
  task automatic nack_txn(input logic [7:0] a);
    logic ack;
    u_host.start();
    u_host.put_byte(a, ack);
    check(ack, 1'b0);
    u_host.stop();
  endtask
  // write address and index, clock left low
  task automatic head(input logic [7:0] idx);
    logic ack;
    u_host.start();
    u_host.put_byte({addr, 1'b0}, ack);
    check(ack, 1'b1);
    u_host.put_byte(idx, ack);
    check(ack, 1'b1);
  endtask
  // block write; index seven always gets a count of three
  task automatic wr_txn(input logic [7:0] idx, input int x);
    logic ack;
    logic [7:0] d;
    head(idx);
    u_host.put_byte(8'(x), ack);
    check(ack, 1'b1);
    for (int i = 0; i < x; i++) begin
      d = (idx + i == BC_INDEX) ? 8'h03 : 8'($urandom);
      exp_q.push_back({8'(idx + i), d});
      if (idx + i < 8) regs[idx + i] = d;
      u_host.put_byte(d, ack);
      check(ack, 1'b1);
    end
    u_host.stop();
  endtask
  // block read: count first, then bytes from the index
  task automatic rd_txn(input logic [7:0] idx);
    logic ack;
    logic [7:0] d, n;
    head(idx);
    u_host.start();
    u_host.put_byte({addr, 1'b1}, ack);
    check(ack, 1'b1);
    u_host.get_byte(n, 1'b1);
    check(n, regs[BC_INDEX] & BC_MASK);
    for (int i = 0; i < n; i++) begin
      u_host.get_byte(d, i < n - 1);
      check(d, (idx + i < 8) ? regs[idx + i] : EMPTY_BYTE);
    end
    u_host.stop();
    repeat (6) @(negedge clk_i);
    check(sda_oe, 1'b0);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h6596));
    rst_i = 1'b1;
    pg = 1'b0;
    wr_ready = 1'b0;
    strap = 1'($urandom);
    foreach (regs[i]) regs[i] = (i == BC_INDEX) ? BC_RESET : 8'h00;
    addr = strap ? ADDR_STRAP1 : ADDR_STRAP0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    nack_txn({addr, 1'b0}); // strap not yet taken
    @(negedge clk_i) pg = 1'b1;
    repeat (5) @(negedge clk_i);
    strap = ~strap; // later strap moves are ignored
    nack_txn({strap ? ADDR_STRAP1 : ADDR_STRAP0, 1'b0});
    rd_txn(8'h00);
    wr_txn(8'h05, 3);
    rd_txn(8'h04);
    rd_txn(8'h06);
    wr_txn(8'h07, 3); // index seven stored, the two past the file buffered only
    rd_txn(8'h05);
    repeat (40) @(posedge clk_i);
    check(16'(exp_q.size()), 16'h0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
